// >>> design/radio_cfg_pkg.sv
// Package with register map, field layout and timing constants for the state machine config
package radio_cfg_pkg;

    // Register map
    localparam logic [7:0] ADDR_SM_CONFIG      = 8'h18;
    localparam int         AUTOCAL_LSB         = 4;
    localparam int         TIMEOUT_LSB         = 2;
    localparam logic [1:0] AUTOCAL_RESET       = 2'h0;
    localparam logic [1:0] TIMEOUT_RESET       = 2'h1;

    // Wake-up timing and calibration interval
    localparam int RIPPLE_BITS    = 6;
    localparam int EXPIRY_BITS    = 9;
    localparam int XOSC_FREQ_KHZ  = 26000;
    localparam int CLK_FREQ_KHZ   = 250000;
    localparam int XOSC_TICK_DIV  = CLK_FREQ_KHZ / XOSC_FREQ_KHZ;
    localparam int SYNC_STAGES    = 3;
    localparam int CAL_EVERY_NTH  = 4;

    // Auto-calibration modes
    typedef enum logic [1:0] {
        AUTOCAL_NEVER   = 2'h0,
        AUTOCAL_TO_TX   = 2'h1,
        AUTOCAL_TO_IDLE = 2'h2,
        AUTOCAL_NTH     = 2'h3
    } autocal_e;

    // Stored setting fields
    typedef struct packed {
        autocal_e   autocal;
        logic [1:0] timeout;
    } sm_config_s;

    // Expiry count for a timeout code: 1, 16, 64, 256
    function automatic logic [EXPIRY_BITS-1:0] expiry_target(input logic [1:0] code);
        logic [EXPIRY_BITS-1:0] result;
        result = 9'h001;
        unique case (code)
            2'h0: result = 9'h001;
            2'h1: result = 9'h010;
            2'h2: result = 9'h040;
            2'h3: result = 9'h100;
        endcase
        return result;
    endfunction : expiry_target

endpackage : radio_cfg_pkg

// >>> design/wakeup_timer.sv
// Wake-up timer: crystal-rate ripple counter expiries before chip ready
`timescale 1ns/1ps
module wakeup_timer #(
    parameter int TICK_DIV = radio_cfg_pkg::XOSC_TICK_DIV
) (
    // Clock and reset
    input  wire logic       mclk_in,
    input  wire logic       rst_in,
    // Control
    input  wire logic       xosc_ok_in,
    input  wire logic [1:0] timeout_in,
    // Status
    output logic            chip_ready_low_out
);
    typedef enum logic [1:0] {WAIT_XOSC, COUNTING, READY} wake_state_e;

    wake_state_e                              state;
    wake_state_e                              next_state;
    logic [$clog2(TICK_DIV+1)-1:0]            div_cnt;
    logic [radio_cfg_pkg::RIPPLE_BITS-1:0]    ripple;
    logic [radio_cfg_pkg::EXPIRY_BITS-1:0]    expiries;
    logic [radio_cfg_pkg::EXPIRY_BITS-1:0]    target;
    wire                                      xosc_tick;
    wire                                      ripple_wrap;

    // Crystal-rate enable; divider keeps one clock domain
    assign xosc_tick   = (div_cnt == $bits(div_cnt)'(TICK_DIV - 1));
    assign ripple_wrap = xosc_tick && (ripple == '1);
    assign target      = radio_cfg_pkg::expiry_target(timeout_in);

    // Sequencer: restarts whenever the crystal drops out
    always_comb begin
        next_state = state;
        unique case (state)
            WAIT_XOSC: if (xosc_ok_in) next_state = COUNTING;
            COUNTING:  if (!xosc_ok_in) next_state = WAIT_XOSC;
                       else if (ripple_wrap && (expiries + 9'h001 == target)) next_state = READY; // [R5]
            READY:     if (!xosc_ok_in) next_state = WAIT_XOSC;
        endcase
    end

    // Counters run only while counting
    always_ff @(posedge mclk_in) begin
        if (rst_in || state != COUNTING) begin
            div_cnt  <= '0;
            ripple   <= '0;
            expiries <= '0;
        end else begin
            div_cnt <= xosc_tick ? '0 : div_cnt + 1'b1; // [R6]
            if (xosc_tick) ripple <= ripple + 1'b1;
            if (ripple_wrap) expiries <= expiries + 9'h001;
        end
    end

    // State and ready flag
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state              <= WAIT_XOSC;
            chip_ready_low_out <= 1'b1;
        end else begin
            state              <= next_state;
            chip_ready_low_out <= (next_state != READY); // [R5]
        end
    end
endmodule : wakeup_timer

// >>> design/radio_sm_config.sv
// Main state machine configuration: auto-calibration select and wake-up timeout
// Function
// [R1] Mode 00: calibrate only on manual strobe
// [R2] Mode 01: calibrate entering transmit or synth-on
// [R3] Mode 10: calibrate returning transmit to idle
// [R4] Mode 11: calibrate every fourth transmit-to-idle
// [R5] Ready low after programmed ripple counter expiries
// [R6] Timeout counted in crystal clock periods
// [R7] Timeout setting survives sleep power-down
// [R8] Software should program timeout code two
`timescale 1ns/1ps
module radio_sm_config #(
    parameter int TICK_DIV = radio_cfg_pkg::XOSC_TICK_DIV
) (
    // Clock and reset
    input  wire logic       mclk_in,
    input  wire logic       rst_in,
    // Register port
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    output logic [7:0]      reg_rdata_out,
    // Radio state machine events
    input  wire logic       synth_calibrate_strobe_in,
    input  wire logic       idle_to_tx_in,
    input  wire logic       idle_to_synth_on_in,
    input  wire logic       tx_to_idle_in,
    input  wire logic       sleep_in,
    // Synthesizer calibration
    output logic            cal_start_out,
    output logic            cal_busy_out,
    input  wire logic       cal_done_in,
    // Power-up
    input  wire logic       xosc_stable_in,
    output logic            chip_ready_low_out
);
    radio_cfg_pkg::sm_config_s              cfg;
    logic [radio_cfg_pkg::SYNC_STAGES-1:0]  xosc_sync;
    logic                                   xosc_ok;
    logic [1:0]                             tx_idle_cnt;
    wire                                    cfg_hit;
    wire                                    cfg_write;
    wire                                    fourth_return;
    wire                                    auto_cal;
    wire                                    cal_request;

    // Register decode
    assign cfg_hit   = (reg_addr_in == radio_cfg_pkg::ADDR_SM_CONFIG);
    assign cfg_write = reg_wr_in && cfg_hit;

    // Setting register; sleep does not touch it so wake-up needs no reprogramming
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            cfg.autocal <= radio_cfg_pkg::autocal_e'(radio_cfg_pkg::AUTOCAL_RESET);
            cfg.timeout <= radio_cfg_pkg::TIMEOUT_RESET;
        end else if (cfg_write) begin // [R7]
            cfg.autocal <= radio_cfg_pkg::autocal_e'(reg_wdata_in[radio_cfg_pkg::AUTOCAL_LSB +: 2]);
            cfg.timeout <= reg_wdata_in[radio_cfg_pkg::TIMEOUT_LSB +: 2];
        end
    end

    // Read data; unused and reserved bits read zero
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            reg_rdata_out <= cfg_hit ? {2'h0, cfg.autocal, cfg.timeout, 2'h0} : 8'h00;
        end
    end

    // Transmit-to-idle counter, only advanced in every-fourth mode
    assign fourth_return = (tx_idle_cnt == 2'(radio_cfg_pkg::CAL_EVERY_NTH - 1));
    always_ff @(posedge mclk_in) begin
        if (rst_in || cfg.autocal != radio_cfg_pkg::AUTOCAL_NTH) begin
            tx_idle_cnt <= 2'h0;
        end else if (tx_to_idle_in) begin
            tx_idle_cnt <= tx_idle_cnt + 2'h1; // [R4]
        end
    end

    // Automatic calibration selection per mode
    assign auto_cal =
        (cfg.autocal == radio_cfg_pkg::AUTOCAL_TO_TX   && (idle_to_tx_in || idle_to_synth_on_in)) || // [R2]
        (cfg.autocal == radio_cfg_pkg::AUTOCAL_TO_IDLE && tx_to_idle_in) ||                          // [R3]
        (cfg.autocal == radio_cfg_pkg::AUTOCAL_NTH     && tx_to_idle_in && fourth_return);           // [R4]
    // Manual strobe always honoured; mode 00 adds nothing automatic
    assign cal_request = synth_calibrate_strobe_in || auto_cal; // [R1]

    // Calibration handshake; requests during a running calibration are merged into it
    always_ff @(posedge mclk_in) begin
        if (rst_in || sleep_in) begin
            cal_start_out <= 1'b0;
            cal_busy_out  <= 1'b0;
        end else begin
            cal_start_out <= cal_request && !cal_busy_out;
            if (cal_request && !cal_busy_out) begin
                cal_busy_out <= 1'b1;
            end else if (cal_done_in) begin
                cal_busy_out <= 1'b0;
            end
        end
    end

    // Crystal-stable pin synchroniser; accepted when last two stages agree
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            xosc_sync <= '0;
            xosc_ok   <= 1'b0;
        end else begin
            xosc_sync <= {xosc_sync[1:0], xosc_stable_in};
            if (xosc_sync[2] == xosc_sync[1]) xosc_ok <= xosc_sync[2];
        end
    end

    // Wake-up timer; crystal is off in sleep, so timing restarts on wake
    wakeup_timer #(
        .TICK_DIV (TICK_DIV)
    ) u_wakeup (
        .mclk_in            (mclk_in),
        .rst_in             (rst_in),
        .xosc_ok_in         (xosc_ok && !sleep_in), // [R6]
        .timeout_in         (cfg.timeout),          // [R5]
        .chip_ready_low_out (chip_ready_low_out)
    );
endmodule : radio_sm_config

// >>> test/radio_sm_config_sva.sv
// Port checker for calibration triggers, register reads and wake-up timing
`timescale 1ns/1ps
module radio_sm_config_sva #(parameter int TICK_DIV = 1) (
    // Clock and register port
    input wire logic       mclk_in,
    input wire logic       rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic       reg_wr_in,
    input wire logic       reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    // Events and status
    input wire logic       synth_calibrate_strobe_in,
    input wire logic       idle_to_tx_in,
    input wire logic       idle_to_synth_on_in,
    input wire logic       tx_to_idle_in,
    input wire logic       sleep_in,
    input wire logic       cal_start_out,
    input wire logic       cal_busy_out,
    input wire logic       cal_done_in,
    input wire logic       xosc_stable_in,
    input wire logic       chip_ready_low_out
);
    logic [5:0]  cfg;
    logic [15:0] ok_cnt;
    wire  [1:0]  mode = cfg[5:4];
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    // Shadow setting and stable-crystal age; sleep must not touch the shadow
    always_ff @(posedge mclk_in) begin
        if (rst_in) cfg <= 6'h04;
        else if (reg_wr_in && reg_addr_in == 8'h18) cfg <= reg_wdata_in[5:0];
        if (rst_in || !xosc_stable_in || sleep_in) ok_cnt <= 16'h0000;
        else if (ok_cnt != 16'hFFFF) ok_cnt <= ok_cnt + 16'h0001;
    end
    never_auto_a: assert property (cal_start_out && $past(mode == 2'h0) |-> $past(synth_calibrate_strobe_in))
        else $error("auto start in mode 0");
    tx_entry_a: assert property (mode == 2'h1 && (idle_to_tx_in || idle_to_synth_on_in) && !cal_busy_out
        && !sleep_in |=> cal_start_out) else $error("no start on tx entry");
    idle_return_a: assert property (mode == 2'h2 && tx_to_idle_in && !cal_busy_out && !sleep_in |=> cal_start_out)
        else $error("no start on idle return");
    nth_cause_a: assert property (cal_start_out && $past(mode == 2'h3 && !synth_calibrate_strobe_in) |-> $past(tx_to_idle_in))
        else $error("mode 3 start without cause");
    busy_drop_a: assert property (cal_busy_out && cal_done_in && !cal_start_out |=> !cal_busy_out)
        else $error("busy held after done");
    ready_time_a: assert property ($fell(chip_ready_low_out) |-> ok_cnt >= 16'(64 * TICK_DIV))
        else $error("ready too early");
    read_back_a: assert property (reg_rd_in && !reg_wr_in && reg_addr_in == 8'h18 |=> reg_rdata_out == {2'h0, cfg[5:2], 2'h0})
        else $error("read data mismatch");
    unmapped_a: assert property (reg_rd_in && reg_addr_in != 8'h18 |=> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
endmodule : radio_sm_config_sva
bind radio_sm_config radio_sm_config_sva #(.TICK_DIV(TICK_DIV)) checker_i (.*);

// >>> test/radio_sm_config_tb.sv
// Directed bench for the state machine configuration block
`timescale 1ns/1ps
module radio_sm_config_tb;
    logic       mclk_in = 1'b0, rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
    logic [3:0] evs = 4'h0; // Strobe, to tx, to synth-on, tx to idle
    logic       sleep_in = 1'b0, cal_done_in = 1'b0, xosc_stable_in = 1'b0;
    logic       cal_start_out, cal_busy_out, chip_ready_low_out;
    int         fails = 0, total_checks = 0, cycles = 0;
    radio_sm_config #(.TICK_DIV(1)) DUT (.*, .synth_calibrate_strobe_in(evs[3]), .idle_to_tx_in(evs[2]),
        .idle_to_synth_on_in(evs[1]), .tx_to_idle_in(evs[0]));
    // Clock and hang guard
    initial forever #2 mclk_in = ~mclk_in;
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            summarize();
        end
    end
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk8
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_in) {reg_addr_in, reg_wdata_in, reg_wr_in} = {a, d, 1'b1};
        @(negedge mclk_in) reg_wr_in = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge mclk_in) {reg_addr_in, reg_rd_in} = {a, 1'b1};
        @(negedge mclk_in) reg_rd_in = 1'b0;
        chk8(reg_rdata_out, e);
    endtask : rd
    // One event pulse, start seen one edge later, then finish the calibration
    task automatic cal(input logic [3:0] e, input logic exp);
        @(negedge mclk_in) evs = e;
        @(negedge mclk_in) evs = 4'h0;
        chk8({7'h0, cal_start_out}, {7'h0, exp});
        @(negedge mclk_in) cal_done_in = 1'b1;
        @(negedge mclk_in) cal_done_in = 1'b0;
        chk8({7'h0, cal_busy_out}, 8'h00);
    endtask : cal
    task automatic check_autocal;
        rd(8'h18, 8'h04);
        rd(8'h3F, 8'h00);
        cal(4'h1, 1'b0);
        cal(4'h4, 1'b0);
        cal(4'h8, 1'b1);
        wr(8'h18, 8'h14);
        cal(4'h4, 1'b1);
        cal(4'h2, 1'b1);
        cal(4'h1, 1'b0);
        wr(8'h18, 8'h24);
        cal(4'h1, 1'b1);
        cal(4'h4, 1'b0);
        wr(8'h18, 8'h34);
        repeat (2) begin
            repeat (3) cal(4'h1, 1'b0);
            cal(4'h1, 1'b1);
        end
    endtask : check_autocal
    // Crystal drops then settles; ready must wait the coded expiries of 64 ticks
    task automatic check_wake(input logic [1:0] code, input int tgt);
        int n;
        n = 0;
        wr(8'h18, {4'h0, code, 2'h0});
        @(negedge mclk_in) xosc_stable_in = 1'b0;
        repeat (8) @(negedge mclk_in);
        chk8({7'h0, chip_ready_low_out}, 8'h01);
        xosc_stable_in = 1'b1;
        while (chip_ready_low_out === 1'b1 && n < 20000) begin
            @(negedge mclk_in);
            n++;
        end
        chk8({7'h0, n >= 64 * tgt && n <= 64 * tgt + 12}, 8'h01);
    endtask : check_wake
    task automatic check_sleep;
        sleep_in = 1'b1;
        repeat (8) @(negedge mclk_in);
        chk8({7'h0, chip_ready_low_out}, 8'h01);
        rd(8'h18, 8'h08);
        sleep_in = 1'b0;
    endtask : check_sleep
    task automatic summarize;
        if (fails == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize
    initial begin
        repeat (12) @(negedge mclk_in);
        rst_in = 1'b0;
        check_autocal();
        check_wake(2'h0, 1);
        check_wake(2'h1, 16);
        check_wake(2'h2, 64);
        check_sleep();
        summarize();
    end
endmodule : radio_sm_config_tb
